// ### verilog/tsm_pkg.sv
// Shared types, chip codes and spreading tables for the ternary spreading modulator
package tsm_pkg;

    // Scheme selector: bits per symbol / chips per symbol
    typedef enum logic [2:0] {
        SCH_1_1  = 3'h0,
        SCH_1_2  = 3'h1,
        SCH_1_4  = 3'h2,
        SCH_1_8  = 3'h3,
        SCH_2_4  = 3'h4,
        SCH_3_8  = 3'h5,
        SCH_4_16 = 3'h6,
        SCH_5_32 = 3'h7
    } tsm_scheme_t;

    // Ternary chip codes
    localparam logic [1:0] CHIP_ZERO = 2'h0;
    localparam logic [1:0] CHIP_POS = 2'h1;
    localparam logic [1:0] CHIP_NEG = 2'h3;

    // Sequence tables, chip n at bits [2n+1:2n]
    localparam logic [63:0] ORTH1_L1 = 64'h0000_0000_0000_0001;
    localparam logic [63:0] ORTH0_L1 = 64'h0000_0000_0000_0000;
    localparam logic [63:0] ORTH1_L2 = 64'h0000_0000_0000_0001;
    localparam logic [63:0] ORTH0_L2 = 64'h0000_0000_0000_000C;
    localparam logic [63:0] ORTH1_L4 = 64'h0000_0000_0000_0041;
    localparam logic [63:0] ORTH0_L4 = 64'h0000_0000_0000_003C;
    localparam logic [63:0] ORTH1_L8 = 64'h0000_0000_0000_4C31;
    localparam logic [63:0] ORTH0_L8 = 64'h0000_0000_0000_314C;
    localparam logic [63:0] BASIC_L4 = 64'h0000_0000_0000_0001;
    localparam logic [63:0] BASIC_L8 = 64'h0000_0000_0000_5340;
    localparam logic [63:0] BASIC_L16 = 64'h0000_0000_5143_100D;
    localparam logic [63:0] BASIC_L32 = 64'h5003_5040_44DF_3443;

    // Reset values
    localparam logic [14:0] PRBS_RESET = 15'h0000;
    localparam logic [4:0] COUNT_RESET = 5'h00;

    typedef struct packed {
        logic valid;       // Chip present this cycle
        logic first;       // First chip of a sequence
        logic last;        // Last chip of a sequence
        logic [1:0] chip;  // Ternary chip code
    } tsm_chip_t;

    // Bits per symbol minus one
    function automatic logic [2:0] tsmBitsM1(input tsm_scheme_t s);
        case (s)
            SCH_2_4: tsmBitsM1 = 3'h1;
            SCH_3_8: tsmBitsM1 = 3'h2;
            SCH_4_16: tsmBitsM1 = 3'h3;
            SCH_5_32: tsmBitsM1 = 3'h4;
            default: tsmBitsM1 = 3'h0;
        endcase
    endfunction

    // Chips per symbol minus one; L is a power of two so this is also the index mask
    function automatic logic [4:0] tsmLenM1(input tsm_scheme_t s);
        case (s)
            SCH_1_2: tsmLenM1 = 5'h01;
            SCH_1_4, SCH_2_4: tsmLenM1 = 5'h03;
            SCH_1_8, SCH_3_8: tsmLenM1 = 5'h07;
            SCH_4_16: tsmLenM1 = 5'h0F;
            SCH_5_32: tsmLenM1 = 5'h1F;
            default: tsmLenM1 = 5'h00;
        endcase
    endfunction

endpackage

// ### verilog/tsm_modulator.sv
// Bit packer, ternary symbol-to-chip mapper and random sequence inversion
`timescale 1ns/1ps

module tsm_modulator
    import tsm_pkg::*;
#(
    parameter logic [63:0] BASIC32 = BASIC_L32 // 32-chip basic sequence
) (
    input wire logic clock,                   // 20 MHz clock
    input wire logic rst,                     // Synchronous reset, active high
    input wire logic frameStart,              // Pulse: new frame, load seed and scheme
    input wire tsm_scheme_t scheme,           // Scheme, taken on frameStart
    input wire logic [14:0] seed,             // Generator seed, taken on frameStart
    input wire logic bitValid,                // Interleaved bit offered
    input wire logic bitData,                 // Interleaved bit
    output logic bitReady,                    // Bit accepted when high with bitValid and frameStart low
    output tsm_chip_t chipOut                 // Chip stream to pulse shaper
);

    typedef enum logic [1:0] {
        ST_COLLECT = 2'b01,
        ST_EMIT = 2'b10
    } tsm_state_t;

    tsm_state_t state;
    tsm_scheme_t activeScheme;
    logic [14:0] prbs;
    logic [4:0] symbol;
    logic [2:0] bitCnt;
    logic [4:0] chipIdx;
    logic keepPolarity;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    wire logic bitTake = bitValid && bitReady && !frameStart;
    wire logic [2:0] bitsM1 = tsmBitsM1(activeScheme);
    wire logic [4:0] lenM1 = tsmLenM1(activeScheme);
    wire logic symTake = bitTake && (bitCnt == bitsM1);
    wire logic [4:0] next_symbol = {symbol[3:0], bitData};
    wire logic prbsOut = prbs[13] ^ prbs[14];
    wire logic [14:0] next_prbs = {prbs[13:0], prbsOut};
    wire logic isOrtho = (bitsM1 == 3'h0);
    wire logic lastChip = (chipIdx == lenM1);

    // Circular shift toward higher indices: c_m[n] = c_0[(n - m) mod L]
    wire logic [4:0] shiftIdx = (chipIdx - symbol) & lenM1;
    wire logic [4:0] tableIdx = isOrtho ? chipIdx : shiftIdx;

    wire logic [63:0] orthWord =
        (activeScheme == SCH_1_1) ? (symbol[0] ? ORTH1_L1 : ORTH0_L1) :
        (activeScheme == SCH_1_2) ? (symbol[0] ? ORTH1_L2 : ORTH0_L2) :
        (activeScheme == SCH_1_4) ? (symbol[0] ? ORTH1_L4 : ORTH0_L4) :
        (symbol[0] ? ORTH1_L8 : ORTH0_L8);
    wire logic [63:0] basicWord =
        (activeScheme == SCH_2_4) ? BASIC_L4 :
        (activeScheme == SCH_3_8) ? BASIC_L8 :
        (activeScheme == SCH_4_16) ? BASIC_L16 : BASIC32;
    wire logic [63:0] seqWord = isOrtho ? orthWord : basicWord;
    wire logic [1:0] rawChip = seqWord[{tableIdx, 1'b0} +: 2];

    // Two's complement of the code negates +1/-1 and leaves zero alone
    wire logic [1:0] polChip = keepPolarity ? rawChip : 2'(-rawChip);

    ////////////////////////////////////////////////////////////////////////////
    // Control

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ST_COLLECT;
            bitReady <= 1'b0;
            bitCnt <= 3'h0;
            chipIdx <= COUNT_RESET;
            symbol <= COUNT_RESET;
        end else begin
            case (state)
                ST_COLLECT: begin
                    bitReady <= !symTake;
                    if (frameStart) begin
                        bitCnt <= 3'h0;
                    end else if (symTake) begin
                        bitCnt <= 3'h0;
                        symbol <= next_symbol;
                        chipIdx <= COUNT_RESET;
                        state <= ST_EMIT;
                    end else if (bitTake) begin
                        bitCnt <= bitCnt + 3'h1;
                        symbol <= next_symbol;
                    end
                end
                ST_EMIT: begin
                    chipIdx <= chipIdx + 5'h01;
                    if (lastChip) begin
                        state <= ST_COLLECT;
                        bitReady <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_COLLECT;
                    bitReady <= 1'b0;
                end
            endcase
        end
    end

    // Generator steps only when a symbol completes; a frame start reloads the seed
    always_ff @(posedge clock) begin
        if (rst) begin
            prbs <= PRBS_RESET;
            keepPolarity <= 1'b1;
            activeScheme <= SCH_1_1;
        end else if (frameStart) begin
            prbs <= seed;
            activeScheme <= scheme;
        end else if (symTake) begin
            prbs <= next_prbs;
            keepPolarity <= prbsOut;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            chipOut <= '0;
        end else begin
            chipOut.valid <= (state == ST_EMIT);
            chipOut.first <= (state == ST_EMIT) && (chipIdx == COUNT_RESET);
            chipOut.last <= (state == ST_EMIT) && lastChip;
            chipOut.chip <= (state == ST_EMIT) ? polChip : CHIP_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [1:0] rawQ;
    logic polQ;
    logic [4:0] chipSeen;
    logic [4:0] lenQ;
    always_ff @(posedge clock) begin
        rawQ <= rawChip;
        polQ <= keepPolarity;
        lenQ <= lenM1;
        chipSeen <= (chipOut.valid && !chipOut.last) ? chipSeen + 5'h01 : COUNT_RESET;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence takeSym;
        symTake && !frameStart;
    endsequence
    sequence emitStart;
        chipOut.valid && chipOut.first;
    endsequence

    a_ready_emit: assert property (state == ST_EMIT |-> !bitReady)
        else $error("bit accepted while emitting");
    a_first_chip: assert property (takeSym |-> ##2 emitStart)
        else $error("sequence did not start two cycles after symbol");
    a_chip_count: assert property (chipOut.valid && chipOut.last |-> chipSeen == lenQ)
        else $error("sequence length differs from L");
    a_back_collect: assert property (chipOut.valid && chipOut.last |-> bitReady)
        else $error("not ready for bits after sequence");
    a_zero_kept: assert property (chipOut.valid && rawQ == CHIP_ZERO |-> chipOut.chip == CHIP_ZERO)
        else $error("zero chip altered by inversion");
    a_polarity_apply: assert property (chipOut.valid && rawQ == CHIP_POS |->
            chipOut.chip == (polQ ? CHIP_POS : CHIP_NEG))
        else $error("polarity not applied");
    a_prbs_step: assert property (takeSym |=> prbs == $past(next_prbs))
        else $error("generator step wrong");
    a_prbs_hold: assert property (!symTake && !frameStart |=> $stable(prbs))
        else $error("generator moved without a symbol");
    a_seed_load: assert property (frameStart |=> prbs == $past(seed))
        else $error("seed not loaded");

    // Each emission step is checked on its own so a stuck index shows at the chip it breaks
    sequence chipRun;
        state == ST_EMIT && !lastChip;
    endsequence
    sequence lastOut;
        chipOut.valid && chipOut.last;
    endsequence

    a_chip_step: assert property (chipRun |=> state == ST_EMIT && chipIdx == $past(chipIdx) + 5'h01)
        else $error("chip index did not advance");
    a_last_ends: assert property (lastOut |=> !chipOut.valid)
        else $error("sequence ran on past its last chip");
    a_polarity_neg: assert property (chipOut.valid && rawQ == CHIP_NEG |->
            chipOut.chip == (polQ ? CHIP_NEG : CHIP_POS))
        else $error("negative chip not handled by inversion");
    a_idle_quiet: assert property (!chipOut.valid |->
            chipOut.chip == CHIP_ZERO && !chipOut.first && !chipOut.last)
        else $error("chip output active outside a sequence");
    a_chip_legal: assert property (chipOut.chip != 2'h2)
        else $error("illegal chip code on output");

    // Bit collection and per-symbol generator use
    a_bit_shift: assert property (bitTake |=> symbol == {$past(symbol[3:0]), $past(bitData)})
        else $error("bit not shifted in as the least significant");
    a_bit_count: assert property (bitTake && !symTake |=> bitCnt == $past(bitCnt) + 3'h1)
        else $error("bit count did not advance");
    a_frame_load: assert property (frameStart |=> bitCnt == 3'h0 && activeScheme == $past(scheme))
        else $error("frame start did not clear the group or load the scheme");
    a_pol_latch: assert property (takeSym |=> keepPolarity == $past(prbsOut))
        else $error("polarity not taken from the generator");

endmodule

// ### testbench/tsm_chip_sink.sv
// Pulse-shaper stand-in that gathers each chip sequence and reports it whole
`timescale 1ns/1ps

module tsm_chip_sink
    import tsm_pkg::*;
(
    input wire logic clock,        // Bench clock
    input wire logic rst,          // Synchronous reset, active high
    input wire tsm_chip_t chipIn,  // Chip stream from the modulator
    output logic seqDone,          // One-cycle pulse after a last chip
    output logic [63:0] seqWord,   // Gathered chips, chip n at bits 2n+1:2n
    output logic [5:0] seqLen      // Chips counted from first to last
);
    ////////////////////////
    // Takes a chip on every valid cycle; the real filter cannot stall either
    always_ff @(posedge clock) begin
        if (rst) begin
            seqDone <= 1'b0;
            seqLen <= 6'h00;
            seqWord <= 64'h0;
        end else begin
            seqDone <= chipIn.valid && chipIn.last;
            if (chipIn.valid && chipIn.first) begin
                seqWord <= {62'h0, chipIn.chip};
                seqLen <= 6'h01;
            end else if (chipIn.valid) begin
                seqWord[2 * seqLen +: 2] <= chipIn.chip;
                seqLen <= seqLen + 6'h01;
            end
        end
    end
endmodule

// ### testbench/tsm_modulator_tb.sv
// Self-checking bench for the ternary spreading modulator
`timescale 1ns/1ps

module tsm_modulator_tb
    import tsm_pkg::*;
;
    logic clock, rst, frameStart, bitValid, bitData, bitReady, seqDone;
    tsm_scheme_t scheme;
    logic [14:0] seed, prbs;
    tsm_chip_t chipOut;
    logic [63:0] seqWord;
    logic [5:0] seqLen;
    logic [69:0] expQ[$];
    int errCount = 0;
    int compares = 0;
    int seedVar = 32'hb706_2ead;
    int activeSc;
    int lenTab[8] = '{1, 2, 4, 8, 4, 8, 16, 32};
    int bitsTab[8] = '{1, 1, 1, 1, 2, 3, 4, 5};

    tsm_modulator i_dut (.clock(clock), .rst(rst), .frameStart(frameStart), .scheme(scheme), .seed(seed),
        .bitValid(bitValid), .bitData(bitData), .bitReady(bitReady), .chipOut(chipOut));
    tsm_chip_sink i_sink (.clock(clock), .rst(rst), .chipIn(chipOut), .seqDone(seqDone), .seqWord(seqWord),
        .seqLen(seqLen));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    ////////////////////////
    function automatic logic [63:0] expSeq(input int sc, input int m, input logic u);
        logic [63:0] base;
        logic [63:0] r;
        logic [1:0] c;
        int k;
        case (sc)
            0: base = m ? ORTH1_L1 : ORTH0_L1;
            1: base = m ? ORTH1_L2 : ORTH0_L2;
            2: base = m ? ORTH1_L4 : ORTH0_L4;
            3: base = m ? ORTH1_L8 : ORTH0_L8;
            4: base = BASIC_L4;
            5: base = BASIC_L8;
            6: base = BASIC_L16;
            default: base = BASIC_L32;
        endcase
        r = 64'h0;
        for (int n = 0; n < lenTab[sc]; n++) begin
            k = (sc < 4) ? n : (n - m + 64) % lenTab[sc];
            c = base[2 * k +: 2];
            r[2 * n +: 2] = (u || c == CHIP_ZERO) ? c : (c == CHIP_POS ? CHIP_NEG : CHIP_POS);
        end
        return r;
    endfunction

    task automatic check(input logic [69:0] seen, input logic [69:0] want);
        compares++;
        if (seen !== want) begin
            errCount++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, errCount);
        if (errCount == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Holds the bit until the edge where ready is seen high
    task automatic sendBit(input logic b);
        int n;
        n = 0;
        bitValid <= 1'b1;
        bitData <= b;
        do begin
            @(posedge clock);
            n++;
        end while (bitReady !== 1'b1 && n < 300);
        if (n >= 300) begin
            errCount++;
            summarize();
        end
    endtask

    // Hold keeps valid up so the next first bit waits out the emission
    task automatic sendSym(input int m, input bit hold);
        logic u;
        m = m & ((1 << bitsTab[activeSc]) - 1);
        for (int i = bitsTab[activeSc] - 1; i >= 0; i--) begin
            sendBit(m[i]);
        end
        u = prbs[13] ^ prbs[14];
        prbs = {prbs[13:0], u};
        expQ.push_back({6'(lenTab[activeSc]), expSeq(activeSc, m, u)});
        if (!hold) begin
            bitValid <= 1'b0;
            @(posedge clock);
        end
    endtask

    task automatic waitIdle();
        int n;
        n = 0;
        while (expQ.size() > 0 && n < 300) begin
            @(posedge clock);
            n++;
        end
        if (expQ.size() > 0) begin
            errCount++;
            summarize();
        end
    endtask

    // Stray bit beside the pulse and changed inputs afterwards must both be ignored
    task automatic startFrame(input int sc, input logic [14:0] s);
        waitIdle();
        bitValid <= 1'b0;
        @(posedge clock);
        frameStart <= 1'b1;
        scheme <= tsm_scheme_t'(sc);
        seed <= s;
        bitValid <= 1'b1;
        bitData <= 1'b1;
        @(posedge clock);
        frameStart <= 1'b0;
        bitValid <= 1'b0;
        scheme <= tsm_scheme_t'(3'(sc + 3));
        seed <= ~s;
        activeSc = sc;
        prbs = s;
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        if (seqDone === 1'b1) begin
            check({seqLen, seqWord}, expQ.size() > 0 ? expQ.pop_front() : 70'h0);
        end
        // Bits are refused while a sequence is still going out
        if (chipOut.valid === 1'b1 && chipOut.last === 1'b0) begin
            check({69'h0, bitReady}, 70'h0);
        end
        if (chipOut.valid === 1'b0) begin
            check({68'h0, chipOut.chip}, {68'h0, CHIP_ZERO});
        end
    end

    ////////////////////////
    initial begin
        rst = 1'b1;
        frameStart = 1'b0;
        scheme = SCH_1_1;
        seed = 15'h0;
        bitValid = 1'b0;
        bitData = 1'b0;
        prbs = 15'h0;
        activeSc = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Cleared generator negates every sequence until a seed is loaded
        sendSym(1, 1'b0);
        for (int sc = 0; sc < 8; sc++) begin
            startFrame(sc, 15'($random(seedVar)));
            for (int j = 0; j < 5; j++) begin
                sendSym(j == 0 ? 0 : (j == 1 ? -1 : $random(seedVar)), j < 4);
            end
        end
        startFrame(7, 15'h4001);
        sendBit(1'b1);
        sendBit(1'b0);
        startFrame(7, 15'h7fff);
        sendSym(19, 1'b0);
        waitIdle();
        summarize();
    end
endmodule
